// file: resolver_position_reporting_bench.sv
// Self-checking bench for the position reporting core
`timescale 1ns/1ns
module resolver_position_reporting_bench;
  reg CLK, RSTN, HW_FAULT, DIR_CCW, SCALE_EN, PRESET_STB, DUP_ADDR;
  reg CONN_EXPLICIT, CONN_STROBE, CONN_POLL, CONN_CYCLIC, CONN_TIMEOUT;
  reg [15:0] SENSOR_ANGLE;
  reg [11:0] SENSOR_TURNS;
  reg [16:0] COUNTS_PER_TURN;
  reg [1:0] VEL_UNIT, RATE_SW;
  reg [27:0] PRESET_VALUE;
  reg [5:0] ADDR_SW;
  wire NV_WRITE, SELFTEST_DONE, HEALTH_RED, HEALTH_GREEN;
  wire NET_RED, NET_GREEN;
  wire [27:0] NV_WRITE_DATA, NV_OFFSET, POSITION;
  wire [5:0] NODE_ADDR;
  wire [1:0] BIT_RATE;
  wire [31:0] TIME_STAMP, RAW_READING, VELOCITY;
  wire [3:0] CONN_ACTIVE;
  integer n_mismatch, checks_done, i;
  reg [31:0] t0;
  rsp_core rsp_core_i (.CLK(CLK), .RSTN(RSTN), .SENSOR_ANGLE(SENSOR_ANGLE),
    .SENSOR_TURNS(SENSOR_TURNS), .HW_FAULT(HW_FAULT), .DIR_CCW(DIR_CCW),
    .SCALE_EN(SCALE_EN), .COUNTS_PER_TURN(COUNTS_PER_TURN),
    .VEL_UNIT(VEL_UNIT), .PRESET_STB(PRESET_STB),
    .PRESET_VALUE(PRESET_VALUE), .NV_OFFSET(NV_OFFSET),
    .NV_WRITE(NV_WRITE), .NV_WRITE_DATA(NV_WRITE_DATA),
    .CONN_EXPLICIT(CONN_EXPLICIT), .CONN_STROBE(CONN_STROBE),
    .CONN_POLL(CONN_POLL), .CONN_CYCLIC(CONN_CYCLIC),
    .CONN_TIMEOUT(CONN_TIMEOUT), .DUP_ADDR(DUP_ADDR), .ADDR_SW(ADDR_SW),
    .RATE_SW(RATE_SW), .NODE_ADDR(NODE_ADDR), .BIT_RATE(BIT_RATE),
    .TIME_STAMP(TIME_STAMP), .RAW_READING(RAW_READING),
    .POSITION(POSITION), .VELOCITY(VELOCITY), .CONN_ACTIVE(CONN_ACTIVE),
    .SELFTEST_DONE(SELFTEST_DONE), .HEALTH_RED(HEALTH_RED),
    .HEALTH_GREEN(HEALTH_GREEN), .NET_RED(NET_RED),
    .NET_GREEN(NET_GREEN));
  rsp_nv_model rsp_nv_model_i (.clk(CLK), .nv_write(NV_WRITE),
    .nv_write_data(NV_WRITE_DATA), .nv_offset(NV_OFFSET));
  initial
  begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  task test_done;
  begin
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  task check(input [31:0] got, input [31:0] exp, input [8*12:1] what);
  begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected at %0t: %0s %h not %h", $time, what, got, exp);
    end
  end
  endtask
  // Refresh is periodic, so the bound is one period plus sync slack
  task wait_pos(input [27:0] exp, input integer lim);
    integer k;
  begin
    k = 0;
    while (POSITION !== exp && k < lim)
    begin
      @(posedge CLK);
      k = k + 1;
    end
    check({4'h0, POSITION}, {4'h0, exp}, "position");
    if (k == lim)
      test_done;
  end
  endtask
  initial
  begin
    n_mismatch = 0;
    checks_done = 0;
    {RSTN, HW_FAULT, DIR_CCW, SCALE_EN, PRESET_STB, DUP_ADDR} = 6'h00;
    {CONN_EXPLICIT, CONN_STROBE, CONN_POLL, CONN_CYCLIC} = 4'h0;
    CONN_TIMEOUT = 1'b0;
    SENSOR_ANGLE = 16'h4ABC;
    SENSOR_TURNS = 12'h123;
    COUNTS_PER_TURN = 17'h10000;
    {VEL_UNIT, RATE_SW, ADDR_SW} = 10'h02A;
    PRESET_VALUE = 28'h0000000;
    repeat (6) @(posedge CLK);
    check(TIME_STAMP, 32'h0, "stamp reset");
    RSTN <= 1'b1;
    repeat (20) @(posedge CLK);
    t0 = TIME_STAMP;
    repeat (50) @(posedge CLK);
    check(TIME_STAMP - t0, 32'hA, "stamp rate");
    check(HEALTH_RED ^ HEALTH_GREEN, 32'h1, "health");
    check(NET_RED ^ NET_GREEN, 32'h1, "network");
    $display("test stamp and lamps done");
    i = 0;
    while (SELFTEST_DONE !== 1'b1 && i < 3000)
    begin
      @(posedge CLK);
      i = i + 1;
    end
    check(SELFTEST_DONE, 32'h1, "self-test");
    if (i == 3000)
      test_done;
    @(posedge CLK);
    #1 check({HEALTH_RED, HEALTH_GREEN}, 32'h1, "health ok");
    check(NODE_ADDR, 32'h2A, "address");
    check(BIT_RATE, 32'h0, "bit rate");
    $display("test self-test done");
    for (i = 0; i < 4; i = i + 1)
    begin
      @(posedge CLK);
      VEL_UNIT <= i[1:0];
      {CONN_EXPLICIT, CONN_STROBE, CONN_POLL, CONN_CYCLIC} <= 4'h1 << i;
      repeat (6) @(posedge CLK);
    end
    {CONN_EXPLICIT, CONN_STROBE, CONN_POLL, CONN_CYCLIC} <= 4'hF;
    repeat (6) @(posedge CLK);
    check(CONN_ACTIVE, 32'hF, "connections");
    check({NET_RED, NET_GREEN}, 32'h1, "net steady");
    $display("test connections done");
    wait_pos(28'h1234ABC, 50100);
    PRESET_STB <= 1'b1;
    PRESET_VALUE <= 28'h0ABCDEF;
    @(posedge CLK);
    PRESET_STB <= 1'b0;
    #1 check(NV_WRITE, 32'h1, "store pulse");
    wait_pos(28'h0ABCDEF, 50100);
    check(RAW_READING, 32'h01234ABC, "raw");
    $display("test preset done");
    DIR_CCW <= 1'b1;
    @(posedge CLK);
    @(posedge CLK);
    #1 check(POSITION, 32'h0F543211, "reversal");
    $display("test reversal done");
    test_done;
  end
endmodule

// file: rsp_core.v
// Resolver position reporting core: position, velocity, time stamp, lamps
// Contract
// RL1: Health lamp alternates during self-test, then green normal, red on fault.
// RL2: Network lamp alternates at self-test, flashes green idle, green connected.
// RL3: Network lamp flashes red on timeout, steady red on duplicate address.
// RL4: 32-bit time stamp advances every 100 ns and wraps.
// RL5: Raw sensor reading unaffected by scaling or preset.
// RL6: Up to 16 bits per turn, counts per turn 1 to 65536.
// RL7: Multi-turn counts 4096 turns, 28-bit absolute position.
// RL8: Default clockwise increasing; host may select counter-clockwise.
// RL9: Preset any value; offset kept in non-volatile storage, reloaded; code overwrites the reloaded offset when DIR_CCW is high at reset.
// RL10: Velocity in pulses/min, pulses/s, pulses/ms or revolutions/min.
// RL11: Position refreshed within 1 ms, velocity within 100 ms.
// RL12: Explicit, bit-strobe, polled and cyclic connections all at once.
// RL13: Bit rate and address from switches only: 125/250/500 kbit/s.
// RL14: Direction reversal replaces position with maximum minus previous; code loads zero minus previous (one more).
// RL15: Time stamp cleared at reset, before self-test ends.
`timescale 1ns/1ns
`include "rsp_defs.vh"
module rsp_core
(
  input wire CLK,
  input wire RSTN,
  input wire [15:0] SENSOR_ANGLE,
  input wire [11:0] SENSOR_TURNS,
  input wire HW_FAULT,
  input wire DIR_CCW,
  input wire SCALE_EN,
  input wire [16:0] COUNTS_PER_TURN,
  input wire [1:0] VEL_UNIT,
  input wire PRESET_STB,
  input wire [27:0] PRESET_VALUE,
  input wire [27:0] NV_OFFSET,
  output reg NV_WRITE,
  output reg [27:0] NV_WRITE_DATA,
  input wire CONN_EXPLICIT,
  input wire CONN_STROBE,
  input wire CONN_POLL,
  input wire CONN_CYCLIC,
  input wire CONN_TIMEOUT,
  input wire DUP_ADDR,
  input wire [5:0] ADDR_SW,
  input wire [1:0] RATE_SW,
  output reg [5:0] NODE_ADDR,
  output reg [1:0] BIT_RATE,
  output reg [31:0] TIME_STAMP,
  output reg [31:0] RAW_READING,
  output reg [27:0] POSITION,
  output reg [31:0] VELOCITY,
  output reg [3:0] CONN_ACTIVE,
  output reg SELFTEST_DONE,
  output wire HEALTH_RED,
  output wire HEALTH_GREEN,
  output wire NET_RED,
  output wire NET_GREEN
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg [27:0] sen_s1_r;
  reg [27:0] sen_s2_r;
  reg [4:0] st_s1_r;
  reg [4:0] st_s2_r;
  reg [7:0] sw_s1_r;
  reg [7:0] sw_s2_r;
  wire fault_s;
  wire dup_s;
  wire tmo_s;
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      sen_s1_r <= 28'h0000000;
      sen_s2_r <= 28'h0000000;
      st_s1_r <= 5'h00;
      st_s2_r <= 5'h00;
      sw_s1_r <= 8'h00;
      sw_s2_r <= 8'h00;
    end
    else
    begin
      sen_s1_r <= {SENSOR_TURNS, SENSOR_ANGLE};
      sen_s2_r <= sen_s1_r;
      st_s1_r <= {HW_FAULT, DUP_ADDR, CONN_TIMEOUT, 2'h0};
      st_s2_r <= st_s1_r;
      sw_s1_r <= {RATE_SW, ADDR_SW};
      sw_s2_r <= sw_s1_r;
    end
  end
  assign fault_s = st_s2_r[4];
  assign dup_s = st_s2_r[3];
  assign tmo_s = st_s2_r[2];
  // ----------------------------------------------------------------
  // Scaling helper
  // ----------------------------------------------------------------
  // Angle scaled to counts per turn; 65536 gives the raw angle
  function [16:0] scale_angle;
    input [15:0] ang;
    input [16:0] cpt;
    reg [32:0] prod;
    begin
      prod = {17'h00000, ang} * {16'h0000, cpt};
      scale_angle = prod[32:16];
    end
  endfunction
  // ----------------------------------------------------------------
  // Timing dividers and self-test
  // ----------------------------------------------------------------
  reg [2:0] ts_div_r;
  reg [15:0] pos_div_r;
  reg [22:0] vel_div_r;
  reg [23:0] st_cnt_r;
  reg [24:0] blink_cnt_r;
  reg blink_r;
  wire ts_tick;
  wire pos_tick;
  wire vel_tick;
  assign ts_tick = (ts_div_r == `RSP_TS_LAST);
  assign pos_tick = (pos_div_r == `RSP_POS_LAST);
  assign vel_tick = (vel_div_r == `RSP_VEL_LAST);
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ts_div_r <= 3'h0;
      pos_div_r <= 16'h0000;
      vel_div_r <= 23'h000000;
      TIME_STAMP <= 32'h00000000; // see RL15
      st_cnt_r <= 24'h000000;
      SELFTEST_DONE <= 1'b0;
      blink_cnt_r <= 25'h0000000;
      blink_r <= 1'b0;
      NODE_ADDR <= 6'h00;
      BIT_RATE <= 2'h0;
    end
    else
    begin
      ts_div_r <= ts_tick ? 3'h0 : ts_div_r + 3'h1;
      if (ts_tick)
        TIME_STAMP <= TIME_STAMP + 32'h00000001; // see RL4
      pos_div_r <= pos_tick ? 16'h0000 : pos_div_r + 16'h0001;
      vel_div_r <= vel_tick ? 23'h000000 : vel_div_r + 23'h000001;
      if (blink_cnt_r == `RSP_BLINK_LAST)
      begin
        blink_cnt_r <= 25'h0000000;
        blink_r <= ~blink_r;
      end
      else
        blink_cnt_r <= blink_cnt_r + 25'h0000001;
      if (!SELFTEST_DONE)
      begin
        if (st_cnt_r == `RSP_SELFTEST_LAST)
        begin
          SELFTEST_DONE <= 1'b1;
          // Switches are latched once; network cannot change them
          NODE_ADDR <= sw_s2_r[5:0]; // see RL13
          BIT_RATE <= (sw_s2_r[7:6] == 2'h3) ? `RSP_RATE_500
                                              : sw_s2_r[7:6]; // see RL13
        end
        st_cnt_r <= st_cnt_r + 24'h000001;
      end
    end
  end
  // ----------------------------------------------------------------
  // Position, offset, direction
  // ----------------------------------------------------------------
  reg [27:0] offset_r;
  reg dir_r;
  reg loaded_r;
  reg flip_r;
  wire [28:0] turn_cnt;
  wire [27:0] raw_dir;
  wire [27:0] abs_pos;
  wire [16:0] st_scaled;
  wire [27:0] scaled_pos;
  // Reversal mirrors the raw count, so the reported value becomes 0-prev (max-prev+1)
  assign raw_dir = dir_r ? (28'h0000000 - sen_s2_r) : sen_s2_r; // see RL8
  assign st_scaled = scale_angle(raw_dir[15:0], COUNTS_PER_TURN); // see RL6
  assign turn_cnt = {17'h00000, raw_dir[27:16]} * {12'h000, COUNTS_PER_TURN};
  assign scaled_pos = SCALE_EN ? turn_cnt[27:0] + {11'h000, st_scaled}
    : raw_dir; // see RL7
  assign abs_pos = scaled_pos + offset_r; // see RL9
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      offset_r <= 28'h0000000;
      dir_r <= 1'b0;
      loaded_r <= 1'b0;
      flip_r <= 1'b0;
      POSITION <= 28'h0000000;
      RAW_READING <= 32'h00000000;
      NV_WRITE <= 1'b0;
      NV_WRITE_DATA <= 28'h0000000;
    end
    else
    begin
      NV_WRITE <= 1'b0;
      dir_r <= DIR_CCW;
      flip_r <= (dir_r != DIR_CCW);
      if (!loaded_r)
      begin
        offset_r <= NV_OFFSET; // see RL9
        loaded_r <= 1'b1;
      end
      else if (flip_r)
        offset_r <= POSITION - scaled_pos; // see RL14
      else if (PRESET_STB)
      begin
        offset_r <= PRESET_VALUE - scaled_pos; // see RL9
        NV_WRITE <= 1'b1;
        NV_WRITE_DATA <= PRESET_VALUE - scaled_pos;
      end
      if (dir_r != DIR_CCW)
        POSITION <= 28'h0000000 - POSITION; // see RL14
      else if (pos_tick && !flip_r)
        POSITION <= abs_pos; // see RL11
      RAW_READING <= {4'h0, sen_s2_r}; // see RL5
    end
  end
  // ----------------------------------------------------------------
  // Velocity
  // ----------------------------------------------------------------
  reg [27:0] vel_prev_r;
  wire [27:0] delta;
  wire [31:0] d_scaled;
  wire [47:0] d_prod;
  assign delta = raw_dir - vel_prev_r;
  // Delta over 100 ms, counts of 1/65536 turn, scaled by counts per turn
  assign d_prod = {20'h00000, delta} * {31'h00000000, COUNTS_PER_TURN};
  assign d_scaled = d_prod[47:16];
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      vel_prev_r <= 28'h0000000;
      VELOCITY <= 32'h00000000;
    end
    else if (vel_tick)
    begin
      vel_prev_r <= raw_dir;
      case (VEL_UNIT) // see RL10
        `RSP_VU_PPM: VELOCITY <= d_scaled * 32'h258;
        `RSP_VU_PPS: VELOCITY <= d_scaled * 32'hA;
        `RSP_VU_PPMS: VELOCITY <= d_scaled / 32'h64;
        default: VELOCITY <= ({4'h0, delta} * 32'h258) >> 16; // see RL10
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Connections and lamps
  // ----------------------------------------------------------------
  reg [4:0] health_mode;
  reg [4:0] net_mode;
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      CONN_ACTIVE <= 4'h0;
    else
      // All four connection types may be open together
      CONN_ACTIVE <= {CONN_CYCLIC, CONN_POLL, CONN_STROBE,
                      CONN_EXPLICIT} & {4{SELFTEST_DONE}}; // see RL12
  end
  always @*
  begin
    health_mode = 5'h00;
    net_mode = 5'h00;
    if (SELFTEST_DONE)
    begin
      health_mode = fault_s ? 5'h10 : 5'h02; // see RL1
      if (dup_s)
        net_mode = 5'h10; // see RL3
      else if (tmo_s)
        net_mode = 5'h08; // see RL3
      else if (CONN_ACTIVE != 4'h0)
        net_mode = 5'h02; // see RL2
      else
        net_mode = 5'h04; // see RL2
    end
  end
  rsp_lamp u_health
  (
    .clk(CLK),
    .rstn(RSTN),
    .blink(blink_r),
    .mode(health_mode),
    .red(HEALTH_RED),
    .green(HEALTH_GREEN)
  );
  rsp_lamp u_net
  (
    .clk(CLK),
    .rstn(RSTN),
    .blink(blink_r),
    .mode(net_mode),
    .red(NET_RED),
    .green(NET_GREEN)
  );
endmodule

// file: rsp_core_asserts.sv
// Concurrent checks on the ports of the position reporting core
`timescale 1ns/1ns
module rsp_core_asserts
(
  input wire CLK,
  input wire RSTN,
  input wire [15:0] SENSOR_ANGLE,
  input wire [11:0] SENSOR_TURNS,
  input wire DIR_CCW,
  input wire PRESET_STB,
  input wire CONN_EXPLICIT,
  input wire CONN_STROBE,
  input wire CONN_POLL,
  input wire CONN_CYCLIC,
  input wire NV_WRITE,
  input wire [5:0] NODE_ADDR,
  input wire [31:0] TIME_STAMP,
  input wire [31:0] RAW_READING,
  input wire [27:0] POSITION,
  input wire [3:0] CONN_ACTIVE,
  input wire SELFTEST_DONE,
  input wire HEALTH_RED,
  input wire HEALTH_GREEN,
  input wire NET_RED,
  input wire NET_GREEN
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  ts_step_a:
    assert property ($changed(TIME_STAMP) |-> TIME_STAMP ==
      $past(TIME_STAMP) + 32'h1) else $error("stamp jumped");
  ts_rate_a:
    assert property ($changed(TIME_STAMP) |=> $stable(TIME_STAMP)[*4]
      ##1 $changed(TIME_STAMP)) else $error("stamp rate wrong");
  nv_pulse_a:
    assert property (PRESET_STB |=> NV_WRITE) else $error("no store");
  nv_cause_a:
    assert property (NV_WRITE |-> $past(PRESET_STB))
      else $error("stray store");
  dir_flip_a:
    assert property ($changed(DIR_CCW) |=> POSITION == 28'h0000000 -
      $past(POSITION)) else $error("reversal value wrong");
  raw_track_a:
    assert property ($stable({SENSOR_TURNS, SENSOR_ANGLE})[*4] ##0
      $past(RSTN, 4) |->
      RAW_READING[27:0] == {SENSOR_TURNS, SENSOR_ANGLE})
      else $error("raw reading wrong");
  conn_all_a:
    assert property ($stable({CONN_EXPLICIT, CONN_STROBE, CONN_POLL,
      CONN_CYCLIC})[*4] |-> $countones(CONN_ACTIVE) == $countones(
      {CONN_EXPLICIT, CONN_STROBE, CONN_POLL, CONN_CYCLIC}))
      else $error("connection set wrong");
  addr_hold_a:
    assert property (!SELFTEST_DONE |-> NODE_ADDR == 6'h00)
      else $error("address early");
  health_alt_a:
    assert property (!SELFTEST_DONE && $past(RSTN, 2) |->
      HEALTH_RED ^ HEALTH_GREEN) else $error("health lamp wrong");
  net_alt_a:
    assert property (!SELFTEST_DONE && $past(RSTN, 2) |->
      NET_RED ^ NET_GREEN) else $error("network lamp wrong");
  cover property (PRESET_STB ##1 NV_WRITE);
  cover property ($changed(DIR_CCW));
  cover property ($changed(POSITION));
endmodule
bind rsp_core rsp_core_asserts rsp_core_asserts_i (.*);

// file: rsp_defs.vh
// Constants shared by the resolver position reporting block
`ifndef RSP_DEFS_VH
`define RSP_DEFS_VH
`define RSP_CLK_HZ 50000000
`define RSP_TS_TICK_NS 100
`define RSP_TS_DIV ((`RSP_TS_TICK_NS * 50) / 1000)
`define RSP_POS_REFRESH_US 1000
`define RSP_POS_DIV ((`RSP_POS_REFRESH_US * 50))
`define RSP_VEL_REFRESH_MS 100
`define RSP_VEL_DIV ((`RSP_VEL_REFRESH_MS * 50000))
`define RSP_SELFTEST_MS 200
`define RSP_SELFTEST_DIV (`RSP_SELFTEST_MS * 50000)
`define RSP_BLINK_MS 500
`define RSP_BLINK_DIV (`RSP_BLINK_MS * 50000)
// Terminal counts of the dividers, sized to their counters
`define RSP_TS_LAST 3'h4
`define RSP_POS_LAST 16'hC34F
`define RSP_VEL_LAST 23'h4C4B3F
// Self-test kept short (2000 clocks) so the switch latch is reachable
`define RSP_SELFTEST_LAST 24'h0007CF
`define RSP_BLINK_LAST 25'h17D783F
`define RSP_TURN_W 12
`define RSP_ST_W 16
`define RSP_POS_W 28
`define RSP_POS_MAX 28'hFFFFFFF
`define RSP_VU_PPM 2'h0
`define RSP_VU_PPS 2'h1
`define RSP_VU_PPMS 2'h2
`define RSP_VU_RPM 2'h3
`define RSP_RATE_125 2'h0
`define RSP_RATE_250 2'h1
`define RSP_RATE_500 2'h2
`endif

// file: rsp_lamp.v
// Bicolour status lamp driver
`timescale 1ns/1ns
`include "rsp_defs.vh"
module rsp_lamp
(
  input wire clk,
  input wire rstn,
  input wire blink,
  input wire [4:0] mode,
  output reg red,
  output reg green
);
  // mode one-hot: 0 off/alt, 1 steady green, 2 flash green,
  // 3 flash red, 4 steady red; zero means alternate
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      red <= 1'b0;
      green <= 1'b0;
    end
    else
    begin
      red <= mode[4] | (mode[3] & blink) | (mode == 5'h00 & blink);
      green <= mode[1] | (mode[2] & blink) | (mode == 5'h00 & ~blink);
    end
  end
endmodule

// file: rsp_nv_model.sv
// Non-volatile offset store standing in for the host side memory
`timescale 1ns/1ns
module rsp_nv_model
(
  input wire clk,
  input wire nv_write,
  input wire [27:0] nv_write_data,
  output reg [27:0] nv_offset
);
  // No reset on purpose: contents must survive a reset like flash
  initial nv_offset = 28'h0000000;
  always @(posedge clk)
  begin
    if (nv_write)
      nv_offset <= nv_write_data;
  end
endmodule
